// ---- hdl/mfp_router.sv ----
// multifunction pin router: config registers, pin drive and control decode
`timescale 1ns/10ps
module mfp_router (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_en_in,
   input wire logic reg_rd_en_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // internal status flags
   input wire logic [7:0] eeprom_stat_in,
   input wire logic [7:0] system_reference_clock_stat_in,
   input wire logic [7:0] dpll_stat_in,
   input wire logic [7:0] dpll_stat2_in,
   input wire logic twh_updated_in,
   input wire mfp_pkg::mfp_ref_array_t ref_stat_in,
   input wire logic sync_pulse_in,
   input wire logic watchdog_in,
   // control outputs indexed by input function code
   output logic [mfp_pkg::MFP_CODE_COUNT-1:0] ctl_out,
   // general function pins
   input wire logic [mfp_pkg::MFP_PIN_COUNT-1:0] general_function_pins_in,
   output logic [mfp_pkg::MFP_PIN_COUNT-1:0] general_function_pins_out,
   output logic [mfp_pkg::MFP_PIN_COUNT-1:0] general_function_pins_oe_n_out
);
   import mfp_pkg::*;

   typedef struct packed {
      mfp_cfg_array_t cfg;
      logic [7:0] rdata;
      logic [MFP_DIV_WIDTH-1:0] div;
      logic [MFP_PIN_COUNT-1:0] pin;
      logic [MFP_PIN_COUNT-1:0] oe_n;
      logic [MFP_PIN_COUNT-1:0] prev;
      logic [MFP_CODE_COUNT-1:0] ctl;
   } mfp_top_state_t;

   mfp_top_state_t state_q;
   mfp_top_state_t state_d;
   logic rst_s1_q;
   logic rst_n_q;
   logic [MFP_PIN_COUNT-1:0] pin_lvl;
   logic [MFP_PIN_COUNT-1:0] pin_sel;
   logic [MFP_CODE_COUNT-1:0] lvl;
   logic [MFP_CODE_COUNT-1:0] fell;

   mfp_status_if stat_if ();

   // input codes that have a control destination
   function automatic logic mfp_ctl_used(input logic [6:0] code);
      logic u;
      u = 1'b0;
      if (code >= 7'h01 && code <= 7'h05) u = 1'b1;
      if (code >= 7'h10 && code <= 7'h14) u = 1'b1;
      if (code >= 7'h20 && code <= 7'h27) u = 1'b1;
      if (code >= 7'h30 && code <= 7'h37) u = 1'b1;
      if (code >= 7'h40 && code <= MFP_IN_SYNC) u = 1'b1;
      return u;
   endfunction : mfp_ctl_used

   function automatic logic mfp_addr_hit(input logic [15:0] a);
      return (a >= MFP_CFG_FIRST_ADDR) && (a <= MFP_CFG_LAST_ADDR);
   endfunction : mfp_addr_hit

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   assign stat_if.eeprom_stat = eeprom_stat_in;
   assign stat_if.system_reference_clock_stat = system_reference_clock_stat_in;
   assign stat_if.dpll_stat = dpll_stat_in;
   assign stat_if.dpll_stat2 = dpll_stat2_in;
   assign stat_if.twh_updated = twh_updated_in;
   assign stat_if.ref_stat = ref_stat_in;
   assign stat_if.sync_pulse = sync_pulse_in;
   assign stat_if.watchdog = watchdog_in;
   assign stat_if.div32 = state_q.div[MFP_DIV_WIDTH-1];

   mfp_pin_sync u_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_q),
      .ce_in(ce_in),
      .pin_in(general_function_pins_in),
      .level_out(pin_lvl)
   );

   mfp_out_mux u_mux (
      .cfg_in(state_q.cfg),
      .stat(stat_if.sink),
      .sel_out(pin_sel)
   );

   // walk from the highest pin down so the lowest index is written last
   always_comb begin
      lvl = '0;
      fell = '0;
      for (int i = MFP_PIN_COUNT - 1; i >= 0; i--) begin
         if (!state_q.cfg[i][MFP_DIR_BIT] &&
             mfp_ctl_used(state_q.cfg[i][6:0])) begin
            lvl[state_q.cfg[i][6:0]] = pin_lvl[i];
            fell[state_q.cfg[i][6:0]] = state_q.prev[i] & ~pin_lvl[i];
         end
      end
   end

   always_comb begin
      state_d = state_q;
      if (ce_in) begin
         if (reg_wr_en_in && mfp_addr_hit(reg_addr_in)) begin
            state_d.cfg[reg_addr_in[2:0]] = reg_wdata_in;
         end
         if (reg_rd_en_in) begin
            if (mfp_addr_hit(reg_addr_in)) begin
               state_d.rdata = state_q.cfg[reg_addr_in[2:0]];
            end else begin
               state_d.rdata = 8'h00;
            end
         end
         state_d.div = state_q.div + 5'h01;
         state_d.prev = pin_lvl;
         for (int i = 0; i < MFP_PIN_COUNT; i++) begin
            state_d.oe_n[i] = ~state_q.cfg[i][MFP_DIR_BIT];
            state_d.pin[i] = state_q.cfg[i][MFP_DIR_BIT] & pin_sel[i];
         end
         state_d.ctl = lvl;
         // the sync control acts on a falling edge, as a one-cycle pulse
         state_d.ctl[MFP_IN_SYNC] = fell[MFP_IN_SYNC];
         state_d.ctl[MFP_IN_UNUSED] = 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q.cfg <= {MFP_PIN_COUNT{MFP_CFG_RESET}};
         state_q.rdata <= 8'h00;
         state_q.div <= MFP_DIV_RESET;
         state_q.pin <= '0;
         state_q.oe_n <= '1;
         state_q.prev <= '0;
         state_q.ctl <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_rdata_out = state_q.rdata;
   assign ctl_out = state_q.ctl;
   assign general_function_pins_out = state_q.pin;
   assign general_function_pins_oe_n_out = state_q.oe_n;

endmodule : mfp_router

// ---- hdl/mfp_pkg.sv ----
// constants and types shared by the multifunction pin router
package mfp_pkg;

   localparam int unsigned MFP_PIN_COUNT = 8;
   localparam int unsigned MFP_REF_COUNT = 8;
   localparam int unsigned MFP_CODE_COUNT = 128;

   // register window, one byte per pin at consecutive addresses
   localparam logic [15:0] MFP_CFG_FIRST_ADDR = 16'h0200;
   localparam logic [15:0] MFP_CFG_LAST_ADDR = 16'h0207;
   localparam logic [7:0] MFP_CFG_RESET = 8'h00;
   localparam int unsigned MFP_DIR_BIT = 7;

   // system clock divider: a 5-bit counter whose msb gives clock / 32
   localparam int unsigned MFP_DIV_RATIO = 32;
   localparam int unsigned MFP_DIV_WIDTH = $clog2(MFP_DIV_RATIO);
   localparam logic [MFP_DIV_WIDTH-1:0] MFP_DIV_RESET = 5'h00;

   // output function codes
   localparam logic [6:0] MFP_OUT_LOW = 7'h00;
   localparam logic [6:0] MFP_OUT_HIGH = 7'h01;
   localparam logic [6:0] MFP_OUT_DIV32 = 7'h02;
   localparam logic [6:0] MFP_OUT_WDOG = 7'h03;
   localparam logic [6:0] MFP_OUT_EE_FIRST = 7'h04;
   localparam logic [6:0] MFP_OUT_EE_LAST = 7'h06;
   localparam logic [6:0] MFP_OUT_SYS_LOCK = 7'h07;
   localparam logic [6:0] MFP_OUT_SYS_CAL = 7'h08;
   localparam logic [6:0] MFP_OUT_SYS_STABLE = 7'h0b;
   localparam logic [6:0] MFP_OUT_DPLL_FIRST = 7'h10;
   localparam logic [6:0] MFP_OUT_DPLL_LAST = 7'h17;
   localparam logic [6:0] MFP_OUT_CLAMPED = 7'h18;
   localparam logic [6:0] MFP_OUT_TWH_AVAIL = 7'h19;
   localparam logic [6:0] MFP_OUT_TWH_UPD = 7'h1a;
   localparam logic [6:0] MFP_OUT_FAULT_FIRST = 7'h20;
   localparam logic [6:0] MFP_OUT_FAULT_LAST = 7'h27;
   localparam logic [6:0] MFP_OUT_VALID_FIRST = 7'h30;
   localparam logic [6:0] MFP_OUT_VALID_LAST = 7'h37;
   localparam logic [6:0] MFP_OUT_ACT_FIRST = 7'h40;
   localparam logic [6:0] MFP_OUT_ACT_LAST = 7'h47;
   localparam logic [6:0] MFP_OUT_SYNC = 7'h50;

   // status bit positions inside the mirrored status bytes
   localparam int unsigned MFP_SYS_LOCK_BIT = 0;
   localparam int unsigned MFP_SYS_CAL_BIT = 1;
   localparam int unsigned MFP_SYS_STABLE_BIT = 4;
   localparam int unsigned MFP_CLAMPED_BIT = 7;
   localparam int unsigned MFP_TWH_AVAIL_BIT = 6;
   localparam int unsigned MFP_REF_FAULT_BIT = 2;
   localparam int unsigned MFP_REF_VALID_BIT = 3;
   // dpll state byte bit for codes 16..23 in code order
   localparam logic [7:0][2:0] MFP_DPLL_BIT_MAP = {
      3'h7, 3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};

   // input function codes
   localparam logic [6:0] MFP_IN_UNUSED = 7'h00;
   localparam logic [6:0] MFP_IN_SYNC = 7'h45;

   typedef logic [7:0] mfp_byte_t;
   typedef mfp_byte_t [MFP_PIN_COUNT-1:0] mfp_cfg_array_t;
   typedef mfp_byte_t [MFP_REF_COUNT-1:0] mfp_ref_array_t;

endpackage : mfp_pkg

// ---- hdl/mfp_status_if.sv ----
// internal status flags carried from the router top to its output mux
`timescale 1ns/10ps
interface mfp_status_if;
   import mfp_pkg::*;
   logic [7:0] eeprom_stat;
   logic [7:0] system_reference_clock_stat;
   logic [7:0] dpll_stat;
   logic [7:0] dpll_stat2;
   logic twh_updated;
   mfp_ref_array_t ref_stat;
   logic sync_pulse;
   logic watchdog;
   logic div32;

   modport src (
      output eeprom_stat, system_reference_clock_stat, dpll_stat, dpll_stat2,
      output twh_updated, ref_stat, sync_pulse, watchdog, div32
   );
   modport sink (
      input eeprom_stat, system_reference_clock_stat, dpll_stat, dpll_stat2,
      input twh_updated, ref_stat, sync_pulse, watchdog, div32
   );
endinterface : mfp_status_if

// ---- hdl/mfp_pin_sync.sv ----
// two-stage synchroniser bank for the pin inputs
`timescale 1ns/10ps
module mfp_pin_sync (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // pins and synchronised levels
   input wire logic [mfp_pkg::MFP_PIN_COUNT-1:0] pin_in,
   output logic [mfp_pkg::MFP_PIN_COUNT-1:0] level_out
);
   import mfp_pkg::*;

   typedef struct packed {
      logic [MFP_PIN_COUNT-1:0] stage1;
      logic [MFP_PIN_COUNT-1:0] stage2;
   } mfp_sync_state_t;

   mfp_sync_state_t state_q;
   mfp_sync_state_t state_d;

   always_comb begin
      state_d = state_q;
      if (ce_in) begin
         // the first stage feeds only the second stage
         state_d.stage1 = pin_in;
         state_d.stage2 = state_q.stage1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign level_out = state_q.stage2;

endmodule : mfp_pin_sync

// ---- hdl/mfp_out_mux.sv ----
// per-pin selection of the monitored internal signal
`timescale 1ns/10ps
module mfp_out_mux (
   // configuration of all pins
   input wire mfp_pkg::mfp_cfg_array_t cfg_in,
   // internal status flags
   mfp_status_if.sink stat,
   // selected level per pin
   output logic [mfp_pkg::MFP_PIN_COUNT-1:0] sel_out
);
   import mfp_pkg::*;

   function automatic logic mfp_pick(input logic [6:0] code,
                                     input logic [7:0] ee,
                                     input logic [7:0] sys,
                                     input logic [7:0] dp,
                                     input logic [7:0] dp2,
                                     input logic twh,
                                     input mfp_ref_array_t refs,
                                     input logic sync,
                                     input logic wdog,
                                     input logic div);
      logic [6:0] off;
      logic r;
      off = 7'h00;
      r = 1'b0;
      if (code == MFP_OUT_LOW) begin
         r = 1'b0;
      end else if (code == MFP_OUT_HIGH) begin
         r = 1'b1;
      end else if (code == MFP_OUT_DIV32) begin
         r = div;
      end else if (code == MFP_OUT_WDOG) begin
         r = wdog;
      end else if (code >= MFP_OUT_EE_FIRST && code <= MFP_OUT_EE_LAST) begin
         off = code - MFP_OUT_EE_FIRST;
         r = ee[off[2:0]];
      end else if (code == MFP_OUT_SYS_LOCK) begin
         r = sys[MFP_SYS_LOCK_BIT];
      end else if (code == MFP_OUT_SYS_CAL) begin
         r = sys[MFP_SYS_CAL_BIT];
      end else if (code == MFP_OUT_SYS_STABLE) begin
         r = sys[MFP_SYS_STABLE_BIT];
      end else if (code >= MFP_OUT_DPLL_FIRST &&
                   code <= MFP_OUT_DPLL_LAST) begin
         off = code - MFP_OUT_DPLL_FIRST;
         r = dp[MFP_DPLL_BIT_MAP[off[2:0]]];
      end else if (code == MFP_OUT_CLAMPED) begin
         r = dp2[MFP_CLAMPED_BIT];
      end else if (code == MFP_OUT_TWH_AVAIL) begin
         r = dp2[MFP_TWH_AVAIL_BIT];
      end else if (code == MFP_OUT_TWH_UPD) begin
         r = twh;
      end else if (code >= MFP_OUT_FAULT_FIRST &&
                   code <= MFP_OUT_FAULT_LAST) begin
         off = code - MFP_OUT_FAULT_FIRST;
         r = refs[off[2:0]][MFP_REF_FAULT_BIT];
      end else if (code >= MFP_OUT_VALID_FIRST &&
                   code <= MFP_OUT_VALID_LAST) begin
         off = code - MFP_OUT_VALID_FIRST;
         r = refs[off[2:0]][MFP_REF_VALID_BIT];
      end else if (code >= MFP_OUT_ACT_FIRST && code <= MFP_OUT_ACT_LAST) begin
         off = code - MFP_OUT_ACT_FIRST;
         r = (dp2[2:0] == off[2:0]);
      end else if (code == MFP_OUT_SYNC) begin
         r = sync;
      end else begin
         r = 1'b0;
      end
      return r;
   endfunction : mfp_pick

   always_comb begin
      for (int i = 0; i < MFP_PIN_COUNT; i++) begin
         sel_out[i] = mfp_pick(cfg_in[i][6:0], stat.eeprom_stat,
                               stat.system_reference_clock_stat, stat.dpll_stat,
                               stat.dpll_stat2, stat.twh_updated,
                               stat.ref_stat, stat.sync_pulse,
                               stat.watchdog, stat.div32);
      end
   end

endmodule : mfp_out_mux

// ---- tb/mfp_board_model.sv ----
// board logic on the far side of the general function pins
`timescale 1ns/10ps
module mfp_board_model (
   // board levels and router drive
   input wire logic [7:0] board_drive_in,
   input wire logic [7:0] router_out_in,
   input wire logic [7:0] router_oe_n_in,
   // resolved pin levels
   output logic [7:0] pin_level_out
);
   // the board yields on every pin the router drives, so no contention
   assign pin_level_out = (~router_oe_n_in & router_out_in) |
      (router_oe_n_in & board_drive_in);
endmodule : mfp_board_model

// ---- tb/mfp_router_sva.sv ----
// assertions on the ports of the multifunction pin router
`timescale 1ns/10ps
module mfp_router_sva (
   // clock, reset and register port
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_en_in,
   input wire logic reg_rd_en_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // status
   input wire logic [7:0] eeprom_stat_in,
   input wire logic [7:0] dpll_stat_in,
   input wire logic [7:0] dpll_stat2_in,
   input wire mfp_pkg::mfp_ref_array_t ref_stat_in,
   // control and pins
   input wire logic [mfp_pkg::MFP_CODE_COUNT-1:0] ctl_out,
   input wire logic [7:0] general_function_pins_in,
   input wire logic [7:0] general_function_pins_out,
   input wire logic [7:0] general_function_pins_oe_n_out
);
   import mfp_pkg::*;
   mfp_cfg_array_t shadow_q;
   logic in_map;
   logic [7:0] rd_exp;
   logic [7:0] cfg0;
   logic [7:0] dir;
   assign in_map = reg_addr_in >= MFP_CFG_FIRST_ADDR &&
      reg_addr_in <= MFP_CFG_LAST_ADDR;
   assign rd_exp = in_map ? shadow_q[reg_addr_in[2:0]] : 8'h00;
   assign cfg0 = shadow_q[0];
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         dir[i] = shadow_q[i][7];
      end
   end
   // config mirror rebuilt from the write strobes only
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shadow_q <= '0;
      end else if (ce_in && reg_wr_en_in && in_map) begin
         shadow_q[reg_addr_in[2:0]] <= reg_wdata_in;
      end
   end
   // cycles since pin 0 last changed, and since cfg0 has read 8'h82 with
   // the enable high; both saturate, so only settled periods are judged
   logic pin0_q;
   logic [4:0] run_q;
   logic [4:0] cfg_run_q;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin0_q <= 1'b0;
         run_q <= 5'h00;
         cfg_run_q <= 5'h00;
      end else begin
         pin0_q <= general_function_pins_out[0];
         if (general_function_pins_out[0] != pin0_q) begin
            run_q <= 5'h01;
         end else if (run_q != 5'h1f) begin
            run_q <= run_q + 5'h01;
         end
         if (cfg0 != 8'h82 || !ce_in) begin
            cfg_run_q <= 5'h00;
         end else if (cfg_run_q != 5'h1f) begin
            cfg_run_q <= cfg_run_q + 5'h01;
         end
      end
   end
   function automatic logic [2:0] dpll_bit(input logic [2:0] k);
      case (k)
         3'h4: return 3'h6;
         3'h5: return 3'h4;
         3'h6: return 3'h5;
         default: return k;
      endcase
   endfunction : dpll_bit
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_pulse;
      ctl_out[69] ##1 !ctl_out[69];
   endsequence
   a_read_back: assert property (
      ce_in && reg_rd_en_in |=> reg_rdata_out == $past(rd_exp))
      else $error("read data differs from config mirror");
   a_dir_enable: assert property (
      general_function_pins_oe_n_out == ~$past(dir) &&
      (general_function_pins_out & ~$past(dir)) == 8'h00)
      else $error("pin drive differs from direction bit");
   a_static_code: assert property (
      $past(cfg0[7:1]) == 7'h40 |->
      general_function_pins_out[0] == $past(cfg0[0]))
      else $error("static level wrong");
   a_div_period: assert property (
      general_function_pins_out[0] != pin0_q && cfg_run_q >= 5'h14 |->
      run_q == 5'h10)
      else $error("divided clock half period wrong");
   a_eeprom_bits: assert property (
      $past(cfg0) inside {[8'h84:8'h86]} |->
      general_function_pins_out[0] == $past(eeprom_stat_in[cfg0[1:0]]))
      else $error("eeprom flag not mirrored");
   a_dpll_order: assert property (
      $past(cfg0[7:3]) == 5'h12 |-> general_function_pins_out[0] ==
      $past(dpll_stat_in[dpll_bit(cfg0[2:0])]))
      else $error("dpll flag order wrong");
   a_ref_flags: assert property (
      $past(cfg0[7:5] == 3'h5 && !cfg0[3]) |-> general_function_pins_out[0]
      == $past(ref_stat_in[cfg0[2:0]][cfg0[4] ? 3 : 2]))
      else $error("reference flag not mirrored");
   a_active_ref: assert property (
      $past(cfg0[7:3]) == 5'h18 |-> general_function_pins_out[0] ==
      $past(dpll_stat2_in[2:0] == cfg0[2:0]))
      else $error("active reference decode wrong");
   a_unused_low: assert property (
      $past(cfg0) inside {8'h89, 8'h8a, [8'h8c:8'h8f], [8'h9b:8'h9f],
      [8'ha8:8'haf], [8'hb8:8'hbf], [8'hc8:8'hcf], [8'hd1:8'hff]} |->
      !general_function_pins_out[0])
      else $error("unused code drives high");
   a_sync_edge: assert property (
      $fell(general_function_pins_in[0]) && cfg0 == 8'h45 |-> ##3 s_pulse)
      else $error("sync pulse missing or wide");
   a_lowest_pin: assert property (
      $past(cfg0) == 8'h10 && $past(cfg0, 3) == 8'h10 |->
      ctl_out[16] == $past(general_function_pins_in[0], 3))
      else $error("control level not from lowest pin");
endmodule : mfp_router_sva
bind mfp_router mfp_router_sva mfp_router_sva_inst (.clock_in, .arst_n_in,
   .ce_in, .reg_addr_in, .reg_wr_en_in, .reg_rd_en_in, .reg_wdata_in,
   .reg_rdata_out, .eeprom_stat_in, .dpll_stat_in, .dpll_stat2_in,
   .ref_stat_in, .ctl_out, .general_function_pins_in,
   .general_function_pins_out, .general_function_pins_oe_n_out);

// ---- tb/test_multifunction_pin_router.sv ----
// self-checking bench for the multifunction pin router
`timescale 1ns/10ps
module test_multifunction_pin_router;
   import mfp_pkg::*;
   logic clock_in, arst_n_in, ce_in, reg_wr_en_in, reg_rd_en_in;
   logic twh_updated_in, sync_pulse_in, watchdog_in;
   logic [15:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, eeprom_stat_in, system_reference_clock_stat_in;
   logic [7:0] dpll_stat_in, dpll_stat2_in, board_drive;
   logic [7:0] general_function_pins_in, general_function_pins_out;
   logic [7:0] general_function_pins_oe_n_out;
   mfp_ref_array_t ref_stat_in;
   logic [MFP_CODE_COUNT-1:0] ctl_out;
   int miscompares = 0;
   int checks = 0;
   localparam logic [6:0] TAB_CODE [22] = '{7'h00, 7'h01, 7'h03, 7'h05,
      7'h04, 7'h0b, 7'h07, 7'h08, 7'h14, 7'h15, 7'h19, 7'h18, 7'h1a, 7'h23,
      7'h22, 7'h36, 7'h26, 7'h45, 7'h44, 7'h50, 7'h09, 7'h7f};
   // bit k is the expected pin level for TAB_CODE[k]
   localparam logic [21:0] TAB_EXP = 22'h0ab5ae;
   mfp_router mfp_router_inst (.clock_in, .arst_n_in, .ce_in,
      .reg_addr_in, .reg_wr_en_in, .reg_rd_en_in, .reg_wdata_in,
      .reg_rdata_out, .eeprom_stat_in, .system_reference_clock_stat_in, .dpll_stat_in,
      .dpll_stat2_in, .twh_updated_in, .ref_stat_in, .sync_pulse_in,
      .watchdog_in, .ctl_out, .general_function_pins_in,
      .general_function_pins_out, .general_function_pins_oe_n_out);
   mfp_board_model mfp_board_model_inst (.board_drive_in(board_drive),
      .router_out_in(general_function_pins_out),
      .router_oe_n_in(general_function_pins_oe_n_out),
      .pin_level_out(general_function_pins_in));
   task automatic tally_and_finish;
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_en_in = 1'b1;
      @(negedge clock_in);
      reg_wr_en_in = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clock_in);
      reg_addr_in = a;
      reg_rd_en_in = 1'b1;
      @(negedge clock_in);
      reg_rd_en_in = 1'b0;
      check(reg_rdata_out === e, "read data");
   endtask : reg_rd
   // config lands one edge after the write, the pin one edge later
   task automatic set_cfg(input int p, input logic [7:0] v);
      reg_wr(16'h0200 + 16'(p), v);
      repeat (2) @(negedge clock_in);
   endtask : set_cfg
   task automatic wait_pin0(input logic v, output int n);
      n = 0;
      while (general_function_pins_out[0] !== v) begin
         @(negedge clock_in);
         n++;
         if (n > 64) begin
            check(1'b0, "pin 0 wait ran out");
            tally_and_finish();
         end
      end
   endtask : wait_pin0
   task automatic t_registers;
      for (int i = 0; i < 8; i++) begin
         reg_rd(16'h0200 + 16'(i), 8'h00);
         reg_wr(16'h0200 + 16'(i), 8'h06 + 8'(i));
      end
      reg_wr(16'h0208, 8'hff);
      for (int i = -1; i < 9; i++) begin
         reg_rd(16'h0200 + 16'(i), (i < 0 || i > 7) ? 8'h00 : 8'h06 + 8'(i));
      end
   endtask : t_registers
   // with the enable low a write must not land and read data must hold
   task automatic t_enable;
      ce_in = 1'b0;
      reg_wr(16'h0207, 8'h55);
      reg_rd(16'h0207, 8'h00);
      ce_in = 1'b1;
      reg_rd(16'h0207, 8'h0d);
   endtask : t_enable
   task automatic t_outputs;
      foreach (TAB_CODE[k]) begin
         set_cfg(0, {1'b1, TAB_CODE[k]});
         check(general_function_pins_out[0] === TAB_EXP[k], "level");
         check(general_function_pins_oe_n_out[0] === 1'b0, "oe");
      end
      // opposite status everywhere, then every code for the assertions
      {eeprom_stat_in, system_reference_clock_stat_in, dpll_stat_in} = ~24'h021240;
      dpll_stat2_in = 8'hba;
      ref_stat_in = ~ref_stat_in;
      {watchdog_in, twh_updated_in, sync_pulse_in} = 3'h0;
      for (int c = 0; c < 128; c++) begin
         set_cfg(0, {1'b1, 7'(c)});
      end
   endtask : t_outputs
   task automatic t_divider;
      int n;
      set_cfg(0, 8'h82);
      wait_pin0(1'b0, n);
      wait_pin0(1'b1, n);
      wait_pin0(1'b0, n);
      check(n == 16, "divided clock half period");
      wait_pin0(1'b1, n);
      check(n == 16, "divided clock low half");
   endtask : t_divider
   task automatic t_inputs;
      set_cfg(0, 8'h10);
      set_cfg(1, 8'h10);
      board_drive = 8'h02;
      repeat (3) @(negedge clock_in);
      check(ctl_out[16] === 1'b0, "higher pin used");
      check(general_function_pins_oe_n_out[1:0] === 2'b11, "drives");
      board_drive = 8'h01;
      repeat (3) @(negedge clock_in);
      check(ctl_out[16] === 1'b1, "lowest pin ignored");
      set_cfg(0, 8'h45);
      board_drive[0] = 1'b0;
      repeat (3) @(negedge clock_in);
      check(ctl_out[69] === 1'b1, "no sync pulse");
      @(negedge clock_in);
      check(ctl_out[69] === 1'b0, "sync pulse wide");
      board_drive[0] = 1'b1;
      repeat (3) @(negedge clock_in);
      check(ctl_out[69] === 1'b0, "pulse on rising edge");
   endtask : t_inputs
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   initial begin
      {arst_n_in, reg_wr_en_in, reg_rd_en_in} = 3'h0;
      ce_in = 1'b1;
      {reg_addr_in, reg_wdata_in} = 24'h000000;
      {eeprom_stat_in, system_reference_clock_stat_in, dpll_stat_in} = 24'h021240;
      dpll_stat2_in = 8'h45;
      ref_stat_in = '0;
      ref_stat_in[3] = 8'h04;
      ref_stat_in[6] = 8'h08;
      {watchdog_in, twh_updated_in, sync_pulse_in} = 3'h7;
      board_drive = 8'hff;
      repeat (8) @(negedge clock_in);
      arst_n_in = 1'b1;
      repeat (3) @(negedge clock_in);
      t_registers();
      t_enable();
      t_outputs();
      t_divider();
      t_inputs();
      tally_and_finish();
   end
endmodule : test_multifunction_pin_router
